// file: eq_cfg_checker.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------
// port checker for the config slice
// --------------------------------------
module eq_cfg_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic register_eq_control_on,
  input wire logic dp_sink_selected,
  input wire logic preemph_enabled,
  input wire logic sink_cable_adapter_detect,
  input wire logic lane2_eq_apply,
  input wire logic [1:0] preemph_trim,
  input wire logic [1:0] swing_trim,
  input wire logic tmds_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // write of the conditioning register, then a read of it
  sequence s_wr; clk_en && wr_en && wr_addr == 8'h0d; endsequence
  sequence s_rd; clk_en && !wr_en && rd_addr == 8'h0d; endsequence
  AST_RESET_TRIM: assert property ($fell(rst) |-> preemph_trim == 2'h1 && swing_trim == 2'h1)
    else $error("trims not nominal after reset");
  AST_READBACK: assert property (s_wr ##1 s_rd |=> rd_data == ($past(wr_data, 2) & 8'h1f))
    else $error("conditioning readback wrong");
  AST_UNMAPPED: assert property (clk_en && (rd_addr < 8'h0a || rd_addr > 8'h0d) |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  AST_EQ_RSVD: assert property (clk_en && rd_addr inside {[8'h0a:8'h0c]} |=> !rd_data[7] && !rd_data[3])
    else $error("reserved eq bits set");
  AST_HOLD: assert property (!clk_en |=> $stable(rd_data))
    else $error("read data moved while disabled");
  AST_TMDS_ON: assert property ((clk_en && dp_sink_selected && sink_cable_adapter_detect)[*5] |-> tmds_active)
    else $error("tmds mode not active");
  AST_NO_SINK: assert property ((clk_en && !dp_sink_selected)[*5] |-> !tmds_active && preemph_trim == 2'h1)
    else $error("trim or tmds active without sink");
  AST_SWING_IDLE: assert property ((clk_en && preemph_enabled)[*5] |-> swing_trim == 2'h1)
    else $error("swing trimmed with pre-emphasis on");
  AST_EQ_APPLY: assert property ((clk_en && register_eq_control_on && dp_sink_selected)[*5] |-> lane2_eq_apply)
    else $error("equalizer field not applied");
endmodule
bind redriver_eq_output_config eq_cfg_checker chk (.clock(clock), .rst(rst), .clk_en(clk_en),
  .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
  .register_eq_control_on(register_eq_control_on), .dp_sink_selected(dp_sink_selected),
  .preemph_enabled(preemph_enabled), .sink_cable_adapter_detect(sink_cable_adapter_detect),
  .lane2_eq_apply(lane2_eq_apply), .preemph_trim(preemph_trim), .swing_trim(swing_trim),
  .tmds_active(tmds_active));
`default_nettype wire

// file: lane_eq_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------
// analog lane equalizer, gain in tenths of a dB
// --------------------------------------
module lane_eq_model (
  input wire logic hbr2,
  input wire logic eq_apply,
  input wire logic [2:0] eq_code,
  output logic [7:0] gain_tenths
);
  localparam logic [7:0] lo_gain [8] = '{8'h00, 8'h0f, 8'h1e, 8'h28, 8'h32, 8'h3c, 8'h46, 8'h5a};
  localparam logic [7:0] hi_gain [8] = '{8'h00, 8'h23, 8'h3c, 8'h50, 8'h64, 8'h82, 8'h96, 8'hb4};
  // an unapplied field leaves the lane flat
  assign gain_tenths = !eq_apply ? 8'h00 : (hbr2 ? hi_gain[eq_code] : lo_gain[eq_code]);
endmodule
`default_nettype wire

// file: redriver_eq_cfg.svh
`ifndef REDRIVER_EQ_CFG_SVH
`define REDRIVER_EQ_CFG_SVH
// ---------------------------------------------
// register offsets
// ---------------------------------------------
`define OFS_LANE2_EQ_LEVELS_HIGH 8'h0a
`define OFS_LANE3_EQ_LEVELS_LOW 8'h0b
`define OFS_LANE3_EQ_LEVELS_HIGH 8'h0c
`define OFS_OUTPUT_CONDITIONING 8'h0d
// ---------------------------------------------
// field positions and reset values
// ---------------------------------------------
`define EQ_HI_MSB 6
`define EQ_HI_LSB 4
`define EQ_LO_MSB 2
`define EQ_LO_LSB 0
`define BOOST_MSB 4
`define BOOST_LSB 3
`define SWING_BIT 2
`define PRE_MSB 1
`define PRE_LSB 0
`define EQ_RESET 3'h0
`define BOOST_RESET 2'h1
`define SWING_RESET 1'h0
`define PRE_RESET 2'h0
`endif

// file: redriver_eq_output_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "redriver_eq_cfg.svh"
module redriver_eq_output_config (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic register_eq_control_on,
  input wire logic dp_sink_selected,
  input wire logic link_training_on,
  input wire logic [1:0] lane2_trained_level,
  input wire logic [1:0] lane3_trained_level,
  input wire logic preemph_enabled,
  input wire logic sink_cable_adapter_detect,
  output logic lane2_eq_apply,
  output logic [2:0] lane2_eq_code,
  output logic lane3_eq_apply,
  output logic [2:0] lane3_eq_code,
  output logic [1:0] preemph_trim,
  output logic [1:0] swing_trim,
  output logic tmds_active,
  output logic tmds_swing_select,
  output logic [1:0] tmds_preemph_select
);
  // ---------------------------------------------
  // pin synchronisers
  // ---------------------------------------------
  // every pin is asynchronous to clock, so nothing below reads it before two flops
  logic [4:0] sync1; // first stage only, may be metastable
  logic [4:0] sync2; // usable stage
  logic [4:0] next_sync1; // pins bundled for the first stage
  logic eq_on_s, dp_sel_s, train_s, pre_on_s, cad_s;
  logic [1:0] l2_lvl_s, l3_lvl_s;
  logic [1:0] l2_lvl_raw, l3_lvl_raw;
  // bundle the pins
  always_comb begin
    next_sync1 = {register_eq_control_on, dp_sink_selected, link_training_on, preemph_enabled,
                  sink_cable_adapter_detect};
  end
  // two flops per pin
  always_ff @(posedge clock) begin
    if (rst) begin
      // all pins read as low until the stages refill
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else if (clk_en) begin
      sync1 <= next_sync1;
      sync2 <= sync1;
    end
  end
  logic [3:0] lvl1; // first stage of the trained levels
  logic [3:0] lvl2; // usable stage of the trained levels
  logic [3:0] next_lvl1; // level pins bundled for the first stage
  // bundle the trained level pins, lane 2 in the upper half
  always_comb begin
    next_lvl1 = {lane2_trained_level, lane3_trained_level};
  end
  // two flops per level pin; the bits are sampled one by one, so a level that changes
  // while training settles may show a mixed code for one cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      lvl1 <= 4'h0;
      lvl2 <= 4'h0;
    end else if (clk_en) begin
      lvl1 <= next_lvl1;
      lvl2 <= lvl1;
    end
  end
  // split the usable stages back into named signals
  assign {eq_on_s, dp_sel_s, train_s, pre_on_s, cad_s} = sync2;
  assign {l2_lvl_raw, l3_lvl_raw} = lvl2;
  assign l2_lvl_s = l2_lvl_raw;
  assign l3_lvl_s = l3_lvl_raw;
  // ---------------------------------------------
  // configuration registers
  // ---------------------------------------------
  // lane 2 levels 0 and 1 have no writable field here and stay at their reset value
  logic [2:0] eq2 [4]; // lane 2 fields per level
  logic [2:0] eq3 [4]; // lane 3 fields per level
  logic [1:0] boost; // global boost trim
  logic swing_sel; // tmds swing bit
  logic [1:0] pre_sel; // tmds pre-emphasis
  logic [2:0] next_eq2 [4];
  logic [2:0] next_eq3 [4];
  logic [1:0] next_boost;
  logic next_swing_sel;
  logic [1:0] next_pre_sel;
  // write decode
  always_comb begin
    // every field holds its value unless written
    next_eq2 = eq2;
    next_eq3 = eq3;
    next_boost = boost;
    next_swing_sel = swing_sel;
    next_pre_sel = pre_sel;
    // a reserved code 11 is stored as written; the host must keep it out
    // unmapped addresses fall through and change nothing
    if (wr_en) begin
      if (wr_addr == `OFS_LANE2_EQ_LEVELS_HIGH) begin
        next_eq2[2] = wr_data[`EQ_HI_MSB:`EQ_HI_LSB];
        next_eq2[3] = wr_data[`EQ_LO_MSB:`EQ_LO_LSB];
      end else if (wr_addr == `OFS_LANE3_EQ_LEVELS_LOW) begin
        next_eq3[0] = wr_data[`EQ_HI_MSB:`EQ_HI_LSB];
        next_eq3[1] = wr_data[`EQ_LO_MSB:`EQ_LO_LSB];
      end else if (wr_addr == `OFS_LANE3_EQ_LEVELS_HIGH) begin
        next_eq3[2] = wr_data[`EQ_HI_MSB:`EQ_HI_LSB];
        next_eq3[3] = wr_data[`EQ_LO_MSB:`EQ_LO_LSB];
      end else if (wr_addr == `OFS_OUTPUT_CONDITIONING) begin
        next_boost = wr_data[`BOOST_MSB:`BOOST_LSB];
        next_swing_sel = wr_data[`SWING_BIT];
        next_pre_sel = wr_data[`PRE_MSB:`PRE_LSB];
      end
    end
  end
  // register update, defaults on reset
  // clk_en low freezes every field; reset wins over clk_en
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        eq2[i] <= `EQ_RESET;
        eq3[i] <= `EQ_RESET;
      end
      boost <= `BOOST_RESET;
      swing_sel <= `SWING_RESET;
      pre_sel <= `PRE_RESET;
    end else if (clk_en) begin
      eq2 <= next_eq2;
      eq3 <= next_eq3;
      boost <= next_boost;
      swing_sel <= next_swing_sel;
      pre_sel <= next_pre_sel;
    end
  end
  // ---------------------------------------------
  // equalizer selection
  // ---------------------------------------------
  // pick the lane field from trained level or fixed level 1
  // outside training the level input is ignored, so a stale level cannot leak through
  function automatic logic [2:0] pick_eq(input logic [2:0] f0, input logic [2:0] f1,
                                         input logic [2:0] f2, input logic [2:0] f3,
                                         input logic trained, input logic [1:0] lvl);
    logic [2:0] r;
    r = f1;
    if (trained) begin
      case (lvl)
        2'h0: r = f0;
        2'h1: r = f1;
        2'h2: r = f2;
        default: r = f3;
      endcase
    end
    return r;
  endfunction
  logic next_eq_apply;
  logic [2:0] next_l2_code, next_l3_code;
  logic next_tmds;
  logic [1:0] next_pre_trim, next_swing_trim;
  logic [7:0] next_rd;
  // output conditioning; codes carry the gain tables to the analog side
  // trims rest at nominal whenever the sink is not selected
  always_comb begin
    next_eq_apply = eq_on_s && dp_sel_s;
    next_l2_code = pick_eq(eq2[0], eq2[1], eq2[2], eq2[3], train_s, l2_lvl_s);
    next_l3_code = pick_eq(eq3[0], eq3[1], eq3[2], eq3[3], train_s, l3_lvl_s);
    next_tmds = dp_sel_s && cad_s;
    next_pre_trim = redriver_eq_pkg::boost_nominal;
    next_swing_trim = redriver_eq_pkg::boost_nominal;
    if (dp_sel_s) begin
      if (pre_on_s) begin
        next_pre_trim = boost;
      end else begin
        next_swing_trim = boost;
      end
    end
    // read mux, unmapped reads zero
    // reserved bits of every register read back as zero
    next_rd = 8'h00;
    if (rd_addr == `OFS_LANE2_EQ_LEVELS_HIGH) begin
      next_rd = {1'b0, eq2[2], 1'b0, eq2[3]};
    end else if (rd_addr == `OFS_LANE3_EQ_LEVELS_LOW) begin
      next_rd = {1'b0, eq3[0], 1'b0, eq3[1]};
    end else if (rd_addr == `OFS_LANE3_EQ_LEVELS_HIGH) begin
      next_rd = {1'b0, eq3[2], 1'b0, eq3[3]};
    end else if (rd_addr == `OFS_OUTPUT_CONDITIONING) begin
      next_rd = {3'h0, boost, swing_sel, pre_sel};
    end
  end
  // registered outputs
  // every output leaves a flop, so the analog side never sees decode glitches
  always_ff @(posedge clock) begin
    if (rst) begin
      // trims rest at nominal, everything else low
      lane2_eq_apply <= 1'b0;
      lane3_eq_apply <= 1'b0;
      lane2_eq_code <= `EQ_RESET;
      lane3_eq_code <= `EQ_RESET;
      preemph_trim <= `BOOST_RESET;
      swing_trim <= `BOOST_RESET;
      tmds_active <= 1'b0;
      tmds_swing_select <= `SWING_RESET;
      tmds_preemph_select <= `PRE_RESET;
      rd_data <= 8'h00;
    end else if (clk_en) begin
      lane2_eq_apply <= next_eq_apply;
      lane3_eq_apply <= next_eq_apply;
      lane2_eq_code <= next_l2_code;
      lane3_eq_code <= next_l3_code;
      preemph_trim <= next_pre_trim;
      swing_trim <= next_swing_trim;
      tmds_active <= next_tmds;
      // tmds fields are plain register copies; tmds_active tells the lanes when they count
      tmds_swing_select <= swing_sel;
      tmds_preemph_select <= pre_sel;
      rd_data <= next_rd;
    end
  end
endmodule
`default_nettype wire

// file: redriver_eq_output_config_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------
// self-checking bench
// --------------------------------------
module redriver_eq_output_config_tb_top;
  logic clock = 1'b0, rst = 1'b1, clk_en = 1'b1, wr_en = 1'b0;
  logic [7:0] wr_addr = 8'h00, wr_data = 8'h00, rd_addr = 8'h00, rd_data, gain3;
  logic eq_on = 1'b0, dp_sel = 1'b0, training = 1'b0, pre_on = 1'b0, cad = 1'b0, hbr2 = 1'b0;
  logic [1:0] lvl2 = 2'h0, lvl3 = 2'h0, pre_trim, sw_trim, tmds_pre;
  logic ap2, ap3, tmds_act, tmds_sw;
  logic [2:0] code2, code3;
  int err_total = 0, checked = 0;
  // rows: address, written value, value read back
  logic [7:0] rows [6][3] = '{'{8'h0a, 8'hff, 8'h77}, '{8'h0b, 8'ha5, 8'h25}, '{8'h0c, 8'h5a, 8'h52},
    '{8'h0d, 8'h16, 8'h16}, '{8'h09, 8'hff, 8'h00}, '{8'h0e, 8'hff, 8'h00}};
  logic [2:0] eq2 [4] = '{3'h0, 3'h0, 3'h3, 3'h5};
  logic [2:0] eq3 [4] = '{3'h6, 3'h2, 3'h4, 3'h1};
  initial forever #25 clock = ~clock;
  redriver_eq_output_config dut (.clock(clock), .rst(rst), .clk_en(clk_en), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
    .register_eq_control_on(eq_on), .dp_sink_selected(dp_sel), .link_training_on(training),
    .lane2_trained_level(lvl2), .lane3_trained_level(lvl3), .preemph_enabled(pre_on),
    .sink_cable_adapter_detect(cad), .lane2_eq_apply(ap2), .lane2_eq_code(code2), .lane3_eq_apply(ap3),
    .lane3_eq_code(code3), .preemph_trim(pre_trim), .swing_trim(sw_trim), .tmds_active(tmds_act),
    .tmds_swing_select(tmds_sw), .tmds_preemph_select(tmds_pre));
  lane_eq_model eqm (.hbr2(hbr2), .eq_apply(ap3), .eq_code(code3), .gain_tenths(gain3));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one write strobe, released at the next falling edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clock);
    wr_en = 1'b0;
  endtask
  task rd(input logic [7:0] a);
    rd_addr = a;
    @(negedge clock);
  endtask
  task settle;
    repeat (6) @(negedge clock);
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clock);
    rst = 1'b0;
    rd(8'h0d);
    chk(rd_data, 8'h08);
    chk({4'h0, pre_trim, sw_trim}, 8'h05);
    foreach (rows[i]) begin
      wr(rows[i][0], rows[i][1]);
      rd(rows[i][0]);
      chk(rd_data, rows[i][2]);
    end
    wr(8'h0a, 8'h35);
    wr(8'h0b, 8'h62);
    wr(8'h0c, 8'h41);
    eq_on = 1'b1;
    dp_sel = 1'b1;
    training = 1'b1;
    for (int l = 0; l < 4; l++) begin
      lvl2 = 2'(l);
      lvl3 = 2'(l);
      settle;
      chk(8'(code3), 8'(eq3[l]));
      chk(8'(code2), 8'(eq2[l]));
      chk({6'h0, ap2, ap3}, 8'h03);
    end
    chk(gain3, 8'h0f);
    hbr2 = 1'b1;
    #1 chk(gain3, 8'h23);
    @(negedge clock);
    training = 1'b0;
    settle;
    chk(8'(code3), 8'h02);
    chk(8'(code2), 8'h00);
    eq_on = 1'b0;
    // boost lowered, tmds swing high, tmds pre-emphasis high
    wr(8'h0d, 8'h06);
    pre_on = 1'b1;
    cad = 1'b1;
    settle;
    chk({2'h0, ap2, ap3, pre_trim, sw_trim}, 8'h01);
    chk({4'h0, tmds_act, tmds_sw, tmds_pre}, 8'h0e);
    pre_on = 1'b0;
    settle;
    chk({4'h0, pre_trim, sw_trim}, 8'h04);
    wr(8'h0d, 8'h11);
    settle;
    chk({4'h0, pre_trim, sw_trim}, 8'h06);
    chk({4'h0, tmds_act, tmds_sw, tmds_pre}, 8'h09);
    cad = 1'b0;
    settle;
    chk(8'(tmds_act), 8'h00);
    // write with the enable low must be lost
    clk_en = 1'b0;
    wr(8'h0d, 8'h00);
    clk_en = 1'b1;
    rd(8'h0d);
    chk(rd_data, 8'h11);
    rst = 1'b1;
    @(negedge clock);
    rst = 1'b0;
    rd(8'h0c);
    chk(rd_data, 8'h00);
    print_verdict;
  end
  initial begin
    #(50 * 2000);
    err_total++;
    print_verdict;
  end
endmodule
`default_nettype wire

// file: redriver_eq_pkg.sv
package redriver_eq_pkg;
  // boost trim codes
  typedef enum logic [1:0] {
    boost_lower = 2'h0,
    boost_nominal = 2'h1,
    boost_higher = 2'h2,
    boost_reserved = 2'h3
  } boost_e;
  // tmds pre-emphasis codes
  typedef enum logic [1:0] {
    pre_none = 2'h0,
    pre_low = 2'h1,
    pre_high = 2'h2,
    pre_reserved = 2'h3
  } tmds_pre_e;
endpackage
